//--- tou_cpu_model.sv
// Purpose: Processor side that services the dedicated channel 0 request.
// Assumes: Service is a one-cycle acknowledge after lat waiting cycles.
// Notes:   The acknowledge is never repeated while it is still high.
`timescale 1ns/10ps
module tou_cpu_model (
  // Clock and request side
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       chan0_irq,
  input  wire logic       serve_en,
  input  wire logic [3:0] lat,
  output logic            chan0_irq_ack
);
  logic [3:0] wait_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wait_reg, chan0_irq_ack} <= 5'h00;
    end else begin
      chan0_irq_ack <= chan0_irq && serve_en && !chan0_irq_ack && wait_reg == lat;
      wait_reg      <= (chan0_irq && serve_en && !chan0_irq_ack) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule // tou_cpu_model

//--- tou_output_irq.sv
// Purpose: Output units and interrupt logic of a 16-bit timer with seven capture/compare channels.
// Assumes: Counter, compare latches and capture events come from the surrounding timer.
// Notes:   Channel 0 compare-equal doubles as the period-equal event.
//
// Overview of operation
// - Non-zero modes change output on clock edge only.
// - Mode 000 output follows software bit immediately.
// - Mode 001 sets output at compare match.
// - Modes 010/011 toggle/set, period clears.
// - Modes 110/111 toggle/clear, period sets.
// - Mode 100 toggles at every compare match.
// - Mode 101 clears output at compare match.
// - Channel 0 compare and period events coincide.
// - Compare acts in both count directions.
// - Dedicated channel 0 request, shared vector request.
// - Flag sets on capture or compare match.
// - Software may set or clear every flag.
// - Request needs channel and global enable.
// - Channel 0 flag clears when serviced.
// - Vector reports highest enabled pending source.
// - Vector access clears highest pending flag.
// - Lower channel numbers win the vector.
// - Vector values even: 0 none, 14 overflow.
// - Count reaching latch raises compare-equal.
`timescale 1ns/10ps
module tou_output_irq
  import tou_pkg::*;
#(
  parameter int CHANS = CHAN_COUNT,
  parameter int CW    = COUNT_WIDTH
) (
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Timer core
  input  wire logic [CW-1:0]       timer_count,
  input  wire logic                count_tick,
  input  wire logic                timer_clear,
  input  wire logic [CHANS*CW-1:0] channel_compare_latch,
  input  wire logic [CHANS-1:0]    capture_event,
  input  wire logic                overflow_event,
  // Processor interrupt side
  input  wire logic                global_irq_enable,
  input  wire logic                chan0_irq_ack,
  output logic                     chan0_irq,
  output logic                     vector_irq,
  // Output pins
  output logic      [CHANS-1:0]    channel_out
);

  tou_chan_ctrl_type ctrl_reg [CHANS];
  logic [CHANS-1:0]  unit_out_reg;
  logic [CHANS-1:0]  compare_equal;
  logic              period_equal;
  logic              ovf_flag_reg;
  logic              ovf_en_reg;
  logic [3:0]        vector_value;
  logic [CHANS-1:0]  vec_clear;
  logic              vec_clear_ovf;

  // Bus pipeline: address phase captured, data phase acts.
  logic              dp_valid_reg;
  logic              dp_write_reg;
  logic [7:0]        dp_addr_reg;
  logic              addr_phase;

  assign addr_phase = hsel & hready & htrans[1];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else begin
      dp_valid_reg <= addr_phase;
      if (addr_phase) begin
        dp_write_reg <= hwrite;
        dp_addr_reg  <= haddr[7:0];
      end
    end
  end

  logic       wr_now;
  logic       vec_access;
  logic [2:0] wr_chan;
  logic       wr_chan_hit;

  assign wr_now      = dp_valid_reg & dp_write_reg;
  assign vec_access  = dp_valid_reg & (dp_addr_reg == OFS_VECTOR);
  assign wr_chan     = dp_addr_reg[4:2];
  assign wr_chan_hit = wr_now & (dp_addr_reg[7:5] == 3'h0) & (dp_addr_reg[1:0] == 2'h0)
                       & (int'(wr_chan) < CHANS);

  // Compare-equal is sampled only on a count tick so each count value matches once.
  // Since the count is compared, not its direction, matches occur counting up and down.
  genvar g;
  generate
    for (g = 0; g < CHANS; g++) begin : g_chan
      assign compare_equal[g] = count_tick
                                & (timer_count == channel_compare_latch[g*CW +: CW]);

      logic period_ev;
      assign period_ev = period_equal;

      // Output unit; mode 0 path is combinational below, the rest is registered.
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          unit_out_reg[g] <= 1'b0;
        end else if (timer_clear) begin
          unit_out_reg[g] <= 1'b0;
        end else begin
          case (ctrl_reg[g].output_mode_select)
            MODE_OUTPUT: begin
              unit_out_reg[g] <= ctrl_reg[g].output_value_bit;
            end
            MODE_SET: begin
              if (compare_equal[g]) unit_out_reg[g] <= 1'b1;
            end
            MODE_TOGGLE_RST: begin
              if (compare_equal[g]) unit_out_reg[g] <= ~unit_out_reg[g];
              if (period_ev) unit_out_reg[g] <= 1'b0;
            end
            MODE_SET_RST: begin
              if (compare_equal[g]) unit_out_reg[g] <= 1'b1;
              if (period_ev) unit_out_reg[g] <= 1'b0;
            end
            MODE_TOGGLE: begin
              if (compare_equal[g]) unit_out_reg[g] <= ~unit_out_reg[g];
            end
            MODE_RESET: begin
              if (compare_equal[g]) unit_out_reg[g] <= 1'b0;
            end
            MODE_TOGGLE_SET: begin
              if (compare_equal[g]) unit_out_reg[g] <= ~unit_out_reg[g];
              if (period_ev) unit_out_reg[g] <= 1'b1;
            end
            MODE_RESET_SET: begin
              if (compare_equal[g]) unit_out_reg[g] <= 1'b0;
              if (period_ev) unit_out_reg[g] <= 1'b1;
            end
            default: begin
              unit_out_reg[g] <= unit_out_reg[g];
            end
          endcase
        end
      end

      // Mode 0 bypasses the flop so a write shows at once; the decode is a plain NOR
      // of the mode bits, which is why software must not pass through mode 0 by accident.
      assign channel_out[g] = (ctrl_reg[g].output_mode_select == MODE_OUTPUT)
                              ? ctrl_reg[g].output_value_bit : unit_out_reg[g];

      // Control word and flag; a hardware set beats any clear in the same cycle.
      logic hw_set;
      logic sw_hit;
      assign hw_set = ctrl_reg[g].capture_mode ? capture_event[g] : compare_equal[g];
      assign sw_hit = wr_chan_hit & (int'(wr_chan) == g);

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ctrl_reg[g] <= '{capture_mode: 1'b0, output_mode_select: MODE_OUTPUT,
                           channel_irq_enable: 1'b0, output_value_bit: 1'b0,
                           channel_flag: 1'b0};
        end else begin
          if (sw_hit) begin
            ctrl_reg[g].capture_mode       <= hwdata[FLD_CAPTURE];
            ctrl_reg[g].output_mode_select <= tou_mode_type'(hwdata[FLD_MODE_HI:FLD_MODE_LO]);
            ctrl_reg[g].channel_irq_enable <= hwdata[FLD_IRQ_EN];
            ctrl_reg[g].output_value_bit   <= hwdata[FLD_OUT_BIT];
          end
          if (hw_set) begin
            ctrl_reg[g].channel_flag <= 1'b1;
          end else if (sw_hit) begin
            ctrl_reg[g].channel_flag <= hwdata[FLD_FLAG];
          end else if ((g == 0) && chan0_irq_ack) begin
            ctrl_reg[g].channel_flag <= 1'b0;
          end else if (vec_clear[g]) begin
            ctrl_reg[g].channel_flag <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign period_equal = compare_equal[0];

  // Overflow flag and its enable in the timer control word.
  logic tctl_hit;
  assign tctl_hit = wr_now & (dp_addr_reg == OFS_TIMER_CTRL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_flag_reg <= 1'b0;
      ovf_en_reg   <= 1'b0;
    end else begin
      if (tctl_hit) ovf_en_reg <= hwdata[FLD_OVF_EN];
      if (overflow_event) begin
        ovf_flag_reg <= 1'b1;
      end else if (tctl_hit) begin
        ovf_flag_reg <= hwdata[FLD_OVF_FLAG];
      end else if (vec_clear_ovf) begin
        ovf_flag_reg <= 1'b0;
      end
    end
  end

  // Priority encoder: channel 1 highest, overflow lowest, disabled sources ignored.
  always_comb begin
    vector_value  = VEC_NONE;
    vec_clear     = '0;
    vec_clear_ovf = 1'b0;
    if (ovf_flag_reg && ovf_en_reg) begin
      vector_value  = VEC_OVERFLOW;
      vec_clear_ovf = vec_access;
    end
    for (int i = CHANS - 1; i >= 1; i--) begin
      if (ctrl_reg[i].channel_flag && ctrl_reg[i].channel_irq_enable) begin
        vector_value  = 4'(2 * i);
        vec_clear_ovf = 1'b0;
        vec_clear     = '0;
        vec_clear[i]  = vec_access;
      end
    end
  end

  // Dedicated and shared requests; a remaining flag re-raises the shared request.
  assign chan0_irq  = global_irq_enable & ctrl_reg[0].channel_flag
                      & ctrl_reg[0].channel_irq_enable;
  assign vector_irq = global_irq_enable & (vector_value != VEC_NONE);

  // Read data is selected in the data phase from current state.
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_valid_reg && !dp_write_reg) begin
      if (dp_addr_reg == OFS_VECTOR) begin
        hrdata[3:0] = vector_value;
      end else if (dp_addr_reg == OFS_TIMER_CTRL) begin
        hrdata[FLD_OVF_FLAG] = ovf_flag_reg;
        hrdata[FLD_OVF_EN]   = ovf_en_reg;
      end else if (dp_addr_reg == OFS_OUT_STATUS) begin
        hrdata[CHANS-1:0] = channel_out;
      end else if ((dp_addr_reg[7:5] == 3'h0) && (dp_addr_reg[1:0] == 2'h0)
                   && (int'(wr_chan) < CHANS)) begin
        // Fields go one by one: the packed control struct is narrower than the word layout.
        hrdata[FLD_FLAG]                = ctrl_reg[wr_chan].channel_flag;
        hrdata[FLD_OUT_BIT]             = ctrl_reg[wr_chan].output_value_bit;
        hrdata[FLD_IRQ_EN]              = ctrl_reg[wr_chan].channel_irq_enable;
        hrdata[FLD_MODE_HI:FLD_MODE_LO] = ctrl_reg[wr_chan].output_mode_select;
        hrdata[FLD_CAPTURE]             = ctrl_reg[wr_chan].capture_mode;
      end
    end
  end

endmodule // tou_output_irq

//--- tou_output_irq_bench.sv
// Purpose: Self-checking bench for the timer output and interrupt block.
// Assumes: Zero-wait bus slave; the bench plays the timer core.
// Notes:   Each mode row runs period, compare, compare from a cleared output.
`timescale 1ns/10ps
module tou_output_irq_bench
  import tou_pkg::*;
;
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, count_tick, timer_clear;
  logic         overflow_event, global_irq_enable, serve_en, chan0_irq_ack, chan0_irq;
  logic         vector_irq;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [3:0]   lat;
  logic [6:0]   capture_event, channel_out;
  logic [15:0]  timer_count;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [111:0] channel_compare_latch;
  wire logic    hready;
  int           bad_count, checks_done, n;
  logic [5:0]   rows [7];
  assign hready = hreadyout;
  tou_output_irq i_tou_output_irq (.*);
  tou_cpu_model i_tou_cpu_model (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic co(input int c, input logic e);
    chk(32'(channel_out[c]), 32'(e));
  endtask
  task automatic summarize();
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic edge_rdy();
    int k;
    k = 0;
    do @(posedge hclk); while (hready !== 1'h1 && ++k < 20);
    if (hready !== 1'h1) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, hwrite, htrans, haddr} <= {1'h1, w, 2'h2, 24'h0, a};
    edge_rdy();
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
    edge_rdy();
    rd = hrdata;
    #1;
  endtask
  // Bits of e: count tick, overflow, timer clear, channel 1 capture.
  task automatic pulse(input logic [3:0] e, input logic [15:0] v);
    @(posedge hclk);
    {count_tick, overflow_event, timer_clear, capture_event[1], timer_count} <= {e, v};
    @(posedge hclk);
    {count_tick, overflow_event, timer_clear, capture_event[1]} <= 4'h0;
    #1;
  endtask
  initial begin
    hclk = 1'h0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    summarize();
  end
  initial begin
    {hresetn, hsel, hwrite, count_tick, timer_clear, overflow_event, serve_en} = 7'h00;
    {global_irq_enable, capture_event, timer_count, htrans, haddr, hwdata} = 90'h0;
    {hsize, lat, bad_count, checks_done} = {3'h2, 4'h3, 32'h0, 32'h0};
    channel_compare_latch[15:0] = 16'h0064;
    for (n = 1; n < 7; n++) channel_compare_latch[16*n +: 16] = 16'(16 * n);
    rows = '{6'h0B, 6'h12, 6'h1B, 6'h22, 6'h28, 6'h35, 6'h3C};
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    chk(32'(channel_out), 32'h0);
    foreach (rows[i]) begin
      bus(1'h1, 8'h04, {24'h0, rows[i][5:3], 5'h00});
      pulse(4'h2, 16'h0);
      co(1, 1'h0);
      pulse(4'h8, 16'h0064);
      co(1, rows[i][2]);
      pulse(4'h8, 16'h0010);
      co(1, rows[i][1]);
      pulse(4'h8, 16'h0010);
      co(1, rows[i][0]);
    end
    bus(1'h1, 8'h08, 32'h4);
    co(2, 1'h1);
    bus(1'h0, OFS_OUT_STATUS, 32'h0);
    chk(rd, 32'h4);
    bus(1'h1, 8'h08, 32'h0);
    co(2, 1'h0);
    bus(1'h1, 8'h04, 32'hE0);
    pulse(4'h8, 16'h0064);
    bus(1'h1, 8'h04, 32'hA0);
    co(1, 1'h1);
    pulse(4'h8, 16'h0010);
    co(1, 1'h0);
    pulse(4'h8, 16'h0064);
    co(1, 1'h0);
    bus(1'h1, 8'h30, 32'hFFFFFFFF);
    bus(1'h0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, 8'h00, 32'h10);
    pulse(4'h8, 16'h0064);
    chk(32'(chan0_irq), 32'h0);
    @(posedge hclk);
    global_irq_enable <= 1'h1;
    #1;
    chk(32'(chan0_irq), 32'h1);
    @(posedge hclk);
    serve_en <= 1'h1;
    for (n = 0; n < 20 && chan0_irq; n++) @(posedge hclk);
    #1;
    chk(32'(chan0_irq), 32'h0);
    if (n == 20) summarize();
    @(posedge hclk);
    serve_en <= 1'h0;
    bus(1'h1, 8'h00, 32'h11);
    chk(32'(chan0_irq), 32'h1);
    bus(1'h1, 8'h00, 32'h10);
    chk(32'(chan0_irq), 32'h0);
    bus(1'h1, 8'h08, 32'h1);
    bus(1'h0, OFS_VECTOR, 32'h0);
    chk(rd, 32'h0);
    for (n = 1; n < 7; n++) bus(1'h1, 8'(4 * n), 32'h11);
    bus(1'h1, OFS_TIMER_CTRL, 32'h2);
    pulse(4'h4, 16'h0);
    chk(32'(vector_irq), 32'h1);
    for (n = 1; n < 8; n++) begin
      bus(1'(n == 3), OFS_VECTOR, 32'h0);
      if (n != 3) chk(rd, 32'(2 * n));
    end
    chk(32'(vector_irq), 32'h0);
    bus(1'h1, 8'h04, 32'h110);
    pulse(4'h1, 16'h0);
    bus(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h111);
    bus(1'h0, OFS_VECTOR, 32'h0);
    chk(rd, 32'h2);
    bus(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h110);
    // A second reset in mid-run must drop pending requests and driven outputs.
    bus(1'h1, 8'h08, 32'h15);
    chk(32'({vector_irq, channel_out[2]}), 32'h3);
    @(posedge hclk);
    hresetn <= 1'h0;
    @(posedge hclk);
    #1;
    chk(32'({vector_irq, channel_out}), 32'h0);
    @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    summarize();
  end
endmodule // tou_output_irq_bench

//--- tou_output_irq_chk.sv
// Purpose: Port assertions for the timer output and interrupt block.
// Assumes: One clock; the bus slave never inserts wait states.
// Notes:   Helper flops mark the bus data phase.
`timescale 1ns/10ps
module tou_output_irq_chk
  import tou_pkg::*;
#(parameter int CHANS = CHAN_COUNT) (
  // Bus side
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp,
  // Timer and interrupt side
  input wire logic             count_tick,
  input wire logic             timer_clear,
  input wire logic [CHANS-1:0] capture_event,
  input wire logic             global_irq_enable,
  input wire logic             chan0_irq_ack,
  input wire logic             chan0_irq,
  input wire logic             vector_irq,
  input wire logic [CHANS-1:0] channel_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic acc_reg, wr_reg, vec_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {acc_reg, wr_reg, vec_reg} <= 3'h0;
    end else begin
      acc_reg <= hsel & hready & htrans[1];
      wr_reg  <= hsel & hready & htrans[1] & hwrite;
      vec_reg <= hsel & hready & htrans[1] & ~hwrite & (haddr[7:0] == OFS_VECTOR);
    end
  end
  ready_fixed_a: assert property (hreadyout) else $error("ready low");
  resp_okay_a: assert property (!hresp) else $error("error response");
  rdata_idle_a: assert property (!acc_reg |-> hrdata == 32'h0) else $error("idle read data");
  irq_gate_a: assert property (!global_irq_enable |-> !chan0_irq && !vector_irq)
    else $error("request while globally off");
  out_edge_a: assert property (!count_tick && !timer_clear && !wr_reg |=> $stable(channel_out))
    else $error("output moved without event");
  chan0_svc_a: assert property (chan0_irq && chan0_irq_ack && !acc_reg && !count_tick
      && !capture_event[0] |=> !chan0_irq) else $error("serviced request stayed");
  vec_even_a: assert property (vec_reg |-> !hrdata[0] && hrdata[31:4] == 28'h0)
    else $error("odd vector");
  vec_pend_a: assert property (vec_reg && vector_irq |-> hrdata[3:0] != VEC_NONE)
    else $error("empty vector while requesting");
endmodule // tou_output_irq_chk
bind tou_output_irq tou_output_irq_chk #(.CHANS(CHANS)) i_tou_output_irq_chk (.*);

//--- tou_pkg.sv
// Purpose: Shared constants and types for the timer output unit and interrupt vector block.
// Assumes: One 250 MHz clock; registers reached over AHB-Lite with 32-bit words.
// Notes:   Offsets are byte addresses of aligned words.
package tou_pkg;

  localparam int CHAN_COUNT = 7;
  localparam int COUNT_WIDTH = 16;

  // Register byte offsets.
  localparam logic [7:0] OFS_CHAN_CTRL_BASE = 8'h00;  // 0x00..0x18, one word per channel
  localparam logic [7:0] OFS_TIMER_CTRL     = 8'h20;
  localparam logic [7:0] OFS_VECTOR         = 8'h24;
  localparam logic [7:0] OFS_OUT_STATUS     = 8'h28;

  // Channel control field positions.
  localparam int FLD_FLAG     = 0;
  localparam int FLD_OUT_BIT  = 2;
  localparam int FLD_IRQ_EN   = 4;
  localparam int FLD_MODE_LO  = 5;
  localparam int FLD_MODE_HI  = 7;
  localparam int FLD_CAPTURE  = 8;

  // Timer control field positions.
  localparam int FLD_OVF_FLAG = 0;
  localparam int FLD_OVF_EN   = 1;

  // Vector word encodings.
  localparam logic [3:0] VEC_NONE     = 4'h0;
  localparam logic [3:0] VEC_OVERFLOW = 4'hE;

  localparam logic [2:0] CTRL_RESET_MODE = 3'h0;

  typedef enum logic [2:0] {
    MODE_OUTPUT     = 3'h0,
    MODE_SET        = 3'h1,
    MODE_TOGGLE_RST = 3'h2,
    MODE_SET_RST    = 3'h3,
    MODE_TOGGLE     = 3'h4,
    MODE_RESET      = 3'h5,
    MODE_TOGGLE_SET = 3'h6,
    MODE_RESET_SET  = 3'h7
  } tou_mode_type;

  typedef struct packed {
    logic         capture_mode;
    tou_mode_type output_mode_select;
    logic         channel_irq_enable;
    logic         output_value_bit;
    logic         channel_flag;
  } tou_chan_ctrl_type;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b01,
    BUS_WRITE = 2'b10
  } tou_bus_state_type;

endpackage : tou_pkg
